// ===== rtl/wgs_pkg.sv
package wgs_pkg;
  // Register byte offsets on APB
  localparam logic [11:0] ADDR_CON0 = 12'h000;
  localparam logic [11:0] ADDR_CON1 = 12'h004;
  localparam logic [11:0] ADDR_DBR  = 12'h008;
  localparam logic [11:0] ADDR_DBF  = 12'h00c;
  localparam logic [11:0] ADDR_AS0  = 12'h010;
  localparam logic [11:0] ADDR_AS1  = 12'h014;
  localparam logic [11:0] ADDR_STR  = 12'h018;
  localparam logic [11:0] ADDR_CLK  = 12'h01c;
  localparam logic [11:0] ADDR_ISM  = 12'h020;

  // Field positions
  localparam int CON0_EN_BIT  = 7;
  localparam int AS0_SHDN_BIT = 7;
  localparam int AS1_FIXED_BIT = 7;

  // Reset values and constant fields
  localparam logic [7:0] RST_ZERO     = 8'h00;
  localparam logic [7:0] AS1_SET_MASK = 8'h80;
  localparam logic [2:0] MODE_STEER   = 3'h0;
  localparam logic [2:0] MODE_SYNC    = 3'h1;

  // Data source selection codes
  localparam logic [3:0] SEL_PIN  = 4'h0;
  localparam logic [3:0] SEL_CCP1 = 4'h1;
  localparam logic [3:0] SEL_CCP2 = 4'h2;
  localparam logic [3:0] SEL_CCP3 = 4'h3;
  localparam logic [3:0] SEL_CCP4 = 4'h4;
  localparam logic [3:0] SEL_LC1  = 4'h5;
  localparam logic [3:0] SEL_LC2  = 4'h6;
  localparam logic [3:0] SEL_PWM3 = 4'h9;
  localparam logic [3:0] SEL_PWM4 = 4'ha;

  // On-chip sources that feed the generator
  typedef struct packed {
    logic dedicated_input_pin_signal;
    logic capcomp1_output;
    logic capcomp2_output;
    logic capcomp3_output;
    logic capcomp4_output;
    logic logic_cell1_output;
    logic logic_cell2_output;
    logic pwm3_output;
    logic pwm4_output;
  } wgs_data_src_type;

  // Shutdown sources, bit order matches the enable register
  typedef struct packed {
    logic logic_cell_two;
    logic comparator2;
    logic comparator1;
    logic timer_six;
    logic timer_four;
    logic timer_two;
    logic shutdown_pin;
  } wgs_shdn_src_type;
endpackage

// ===== rtl/wgs_sync2.sv
`timescale 1ns/100ps
`default_nettype none
module wgs_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  // Two-flop synchroniser; stage1 feeds only stage two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/wgs_top.sv
// Functional notes
// - Shutdown-enable bit 7 reads one; bits 6..0 writable, reset zero.
// - Bit 6 lets logic cell 2 output trigger shutdown.
// - Bits 5 and 4 let comparator 2 and 1 trigger shutdown.
// - Bits 3 and 2 let timer six and timer four trigger shutdown.
// - Bit 1 lets timer two postscaled output trigger shutdown.
// - Bit 0 lets the routed shutdown pin trigger shutdown.
// - Steer enable one drives waveform through that output's inversion bit.
// - Steer enable zero drives that output's override value.
// - Steering register: overrides D..A in 7..4, enables D..A in 3..0.
// - Steering settings apply only in mode codes 000 and 001.
// - In synchronous steering mode enables are double-buffered.
// - Clock select one picks fast internal osc, zero system clock; reset zero.
// - Reserved source codes connect no data source.
// - Unimplemented register bits read as zero.
// - Mode 000 is steering, 001 synchronous steering.
// - Inversion bit set inverts the output, clear leaves it normal.
// - After shutdown flag clears, outputs hold until next input rising edge.
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module wgs_top
  import wgs_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic                  pready,
  output logic [31:0]           prdata,
  output logic                  pslverr,
  input  wire wgs_data_src_type data_src,
  input  wire wgs_shdn_src_type shdn_src,
  output logic                  fast_clk_sel,
  output logic                  shutdown_req,
  output logic [3:0]            drive_out
);
  // Registers
  logic [7:0] con0, con1, dbr, dbf, as0, as1, strg, clksel, ism;
  logic [3:0] steer_active;
  logic [3:0] shdn_hold_out;
  logic       in_sync, in_prev, in_rise, data_in, shdn_hold;
  logic [8:0] src_sync;
  logic [6:0] shdn_sync;
  logic       wr_en, rd_en, mode_steer, mode_sync;
  logic [3:0] next_drive;

  // External pins and other-domain sources are synchronised first
  wgs_sync2 #(.WIDTH(9)) u_src_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (data_src),
    .sync_out (src_sync)
  );
  wgs_sync2 #(.WIDTH(7)) u_shdn_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (shdn_src),
    .sync_out (shdn_sync)
  );

  // Zero-wait APB slave
  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !penable && !pwrite;
  assign pslverr = 1'b0;

  // Register writes; unimplemented bits never store
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      con0   <= RST_ZERO;
      con1   <= RST_ZERO;
      dbr    <= RST_ZERO;
      dbf    <= RST_ZERO;
      as1    <= AS1_SET_MASK;
      strg   <= RST_ZERO;
      clksel <= RST_ZERO;
      ism    <= RST_ZERO;
    end else if (wr_en) begin
      if (paddr == ADDR_CON0) begin
        con0 <= pwdata[7:0] & 8'hc7;
      end else if (paddr == ADDR_CON1) begin
        con1 <= pwdata[7:0] & 8'h0f;
      end else if (paddr == ADDR_DBR) begin
        dbr <= pwdata[7:0] & 8'h3f;
      end else if (paddr == ADDR_DBF) begin
        dbf <= pwdata[7:0] & 8'h3f;
      end else if (paddr == ADDR_AS1) begin
        as1 <= pwdata[7:0] | AS1_SET_MASK;
      end else if (paddr == ADDR_STR) begin
        strg <= pwdata[7:0];
      end else if (paddr == ADDR_CLK) begin
        clksel <= pwdata[7:0] & 8'h01;
      end else if (paddr == ADDR_ISM) begin
        ism <= pwdata[7:0] & 8'h0f;
      end
    end
  end

  // Shutdown status: hardware set wins over software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      as0 <= 8'h14;
    end else begin
      if (wr_en && paddr == ADDR_AS0) begin
        as0 <= pwdata[7:0] & 8'hfc;
      end
      if (shutdown_req) begin
        as0[AS0_SHDN_BIT] <= 1'b1;
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd_en) begin
      if (paddr == ADDR_CON0) begin
        prdata <= {24'h0, con0};
      end else if (paddr == ADDR_CON1) begin
        prdata <= {24'h0, con1 | {2'b00, data_in, 5'b0}};
      end else if (paddr == ADDR_DBR) begin
        prdata <= {24'h0, dbr};
      end else if (paddr == ADDR_DBF) begin
        prdata <= {24'h0, dbf};
      end else if (paddr == ADDR_AS0) begin
        prdata <= {24'h0, as0};
      end else if (paddr == ADDR_AS1) begin
        prdata <= {24'h0, as1};
      end else if (paddr == ADDR_STR) begin
        prdata <= {24'h0, strg};
      end else if (paddr == ADDR_CLK) begin
        prdata <= {24'h0, clksel};
      end else if (paddr == ADDR_ISM) begin
        prdata <= {24'h0, ism};
      end else begin
        prdata <= '0;
      end
    end
  end

  assign fast_clk_sel = clksel[0];

  // Data source selection; reserved codes give a quiet low
  always_comb begin
    case (ism[3:0])
      SEL_PIN:  data_in = src_sync[8];
      SEL_CCP1: data_in = src_sync[7];
      SEL_CCP2: data_in = src_sync[6];
      SEL_CCP3: data_in = src_sync[5];
      SEL_CCP4: data_in = src_sync[4];
      SEL_LC1:  data_in = src_sync[3];
      SEL_LC2:  data_in = src_sync[2];
      SEL_PWM3: data_in = src_sync[1];
      SEL_PWM4: data_in = src_sync[0];
      default:  data_in = 1'b0;
    endcase
  end

  // Enabled sources ORed into one request
  assign shutdown_req = |(shdn_sync & as1[6:0]);

  // Input edge detector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_prev <= 1'b0;
    end else begin
      in_prev <= data_in;
    end
  end
  assign in_rise = data_in && !in_prev;
  assign in_sync = in_rise;

  assign mode_steer = con0[2:0] == MODE_STEER;
  assign mode_sync  = con0[2:0] == MODE_SYNC;

  // Active steer enables; buffered in sync mode until input edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      steer_active <= '0;
    end else if (mode_steer) begin
      steer_active <= strg[3:0];
    end else if (mode_sync && in_sync) begin
      steer_active <= strg[3:0];
    end
  end

  // Shutdown hold: released only at input rising edge once flag clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shdn_hold <= 1'b0;
    end else if (as0[AS0_SHDN_BIT]) begin
      shdn_hold <= 1'b1;
    end else if (in_rise) begin
      shdn_hold <= 1'b0;
    end
  end

  // Shutdown levels per output from the state control fields
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_out
      localparam int FLD = (g % 2 == 0) ? 2 : 4;
      always_comb begin
        case (as0[FLD +: 2])
          2'b11:   shdn_hold_out[g] = 1'b1;
          2'b10:   shdn_hold_out[g] = 1'b0;
          default: shdn_hold_out[g] = con1[g];
        endcase
      end
      always_comb begin
        if (shdn_hold || !con0[CON0_EN_BIT]) begin
          next_drive[g] = shdn_hold ? shdn_hold_out[g] : con1[g];
        end else if (mode_steer || mode_sync) begin
          next_drive[g] = steer_active[g] ? (data_in ^ con1[g])
                                          : strg[4 + g];
        end else begin
          next_drive[g] = con1[g];
        end
      end
    end
  endgenerate

  // Registered outputs to the power stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_out <= '0;
    end else begin
      drive_out <= next_drive;
    end
  end

  // Checks
  chk_as1_top_one: assert property (@(posedge pclk) disable iff (!presetn)
    as1[AS1_FIXED_BIT]) else $error("shutdown enable bit 7 not one");
  chk_shdn_or: assert property (@(posedge pclk) disable iff (!presetn)
    shutdown_req == |(shdn_sync & as1[6:0])) else $error("shutdown or wrong");
  chk_steer_wave: assert property (@(posedge pclk) disable iff (!presetn)
    (con0[CON0_EN_BIT] && !shdn_hold && mode_steer && steer_active[0])
      |=> drive_out[0] == ($past(data_in) ^ $past(con1[0])))
    else $error("steered output wrong");
  chk_steer_ovr: assert property (@(posedge pclk) disable iff (!presetn)
    (con0[CON0_EN_BIT] && !shdn_hold && mode_steer && !steer_active[1])
      |=> drive_out[1] == $past(strg[5])) else $error("override wrong");
  chk_sync_buf: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_sync && !in_sync) |=> $stable(steer_active))
    else $error("sync steer changed early");
  chk_sync_load: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_sync && in_sync) |=> steer_active == $past(strg[3:0]))
    else $error("sync steer not loaded");
  chk_reserved_sel: assert property (@(posedge pclk) disable iff (!presetn)
    (ism[3:0] == 4'h7 || ism[3:0] == 4'h8 || ism[3:0] > SEL_PWM4) |-> !data_in)
    else $error("reserved source connected");
  chk_hold_until: assert property (@(posedge pclk) disable iff (!presetn)
    (shdn_hold && !as0[AS0_SHDN_BIT] && !in_rise) |=> shdn_hold)
    else $error("shutdown released early");
  cov_sync_load: cover property (@(posedge pclk) disable iff (!presetn)
    mode_sync && in_sync);
  cov_shutdown: cover property (@(posedge pclk) disable iff (!presetn)
    shutdown_req ##1 as0[AS0_SHDN_BIT]);
  cov_release: cover property (@(posedge pclk) disable iff (!presetn)
    shdn_hold ##1 !shdn_hold);
endmodule
`default_nettype wire

// ===== sim/wgs_src_model.sv
`timescale 1ns/100ps
`default_nettype none
// Stand-in for the on-chip sources that feed the generator
module wgs_src_model
  import wgs_pkg::*;
(
  input  wire logic             wave,
  input  wire logic [3:0]       target,
  input  wire logic [6:0]       shdn_set,
  output logic                  dummy_unused,
  output wgs_data_src_type      data_src,
  output wgs_shdn_src_type      shdn_src
);
  logic [8:0] one_hot;

  // Only the targeted source carries the wave; all others carry its inverse,
  // so a wrong routing shows up as an inverted output
  assign one_hot = (target < 4'h9) ? (9'h001 << target) : 9'h000;
  assign data_src = wgs_data_src_type'(wave ? one_hot : ~one_hot);
  // Shutdown sources, bit order matching the enable register
  assign shdn_src = wgs_shdn_src_type'(shdn_set);
  assign dummy_unused = 1'b0;
endmodule
`default_nettype wire

// ===== sim/wgs_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module wgs_top_tb_top
  import wgs_pkg::*;
;
  logic             pclk = 1'b0;
  logic             presetn, psel, penable, pwrite, wave;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, prdata, rd;
  logic             pready, pslverr, fast_clk_sel, shutdown_req;
  wgs_data_src_type data_src;
  wgs_shdn_src_type shdn_src;
  logic [3:0]       drive_out, target;
  logic [6:0]       shdn_set;
  logic [15:0]      rows [16];
  int               errors, n_tests, i;

  wgs_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .data_src(data_src), .shdn_src(shdn_src),
    .fast_clk_sel(fast_clk_sel), .shutdown_req(shutdown_req), .drive_out(drive_out));
  wgs_src_model src (.wave(wave), .target(target), .shdn_set(shdn_set),
    .dummy_unused(), .data_src(data_src), .shdn_src(shdn_src));

  // Clock at 125 MHz
  always #4 pclk = ~pclk;

  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; waits on pready, never assumes a latency
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Ends when pready is high; only the watchdog bounds this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 8'h00);
    chk(rd, exp);
    chk({pready, pslverr}, 32'h2);
  endtask

  task results;
    if (errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Watchdog sized well past the expected run
  initial begin
    cyc(20000);
    errors++;
    results;
  end

  // Rows: select code, source index (f = none), output for wave high, wave low
  initial begin
    rows = '{16'h08f0, 16'h17f0, 16'h26f0, 16'h35f0, 16'h44f0, 16'h53f0, 16'h62f0,
      16'h7f00, 16'h8f00, 16'h91f0, 16'ha0f0, 16'hbf00, 16'hcf00, 16'hdf00,
      16'hef00, 16'hff00};
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; wave = 1'b0; target = 4'h8; shdn_set = 7'h00;
    errors = 0; n_tests = 0;
    cyc(4);
    presetn <= 1'b1;
    rchk(ADDR_AS1, 32'h80);
    rchk(ADDR_STR, 32'h00);
    rchk(ADDR_CLK, 32'h00);
    rchk(ADDR_ISM, 32'h00);
    wr(ADDR_AS1, 8'hff);
    rchk(ADDR_AS1, 32'hff);
    wr(ADDR_AS1, 8'h00);
    rchk(ADDR_AS1, 32'h80);
    wr(ADDR_CLK, 8'hff);
    rchk(ADDR_CLK, 32'h01);
    chk(fast_clk_sel, 32'h1);
    wr(ADDR_ISM, 8'hff);
    rchk(ADDR_ISM, 32'h0f);
    wr(12'h100, 8'h5a);
    rchk(12'h100, 32'h0);
    wr(ADDR_CLK, 8'h00);
    cyc(1);
    chk(fast_clk_sel, 32'h0);
    // Every select code, all outputs steered, normal polarity
    wr(ADDR_STR, 8'h0f);
    wr(ADDR_CON0, 8'h80);
    for (i = 0; i < 16; i++) begin
      wr(ADDR_ISM, {4'h0, rows[i][15:12]});
      target <= rows[i][11:8];
      wave <= 1'b1;
      cyc(5);
      chk(drive_out, rows[i][7:4]);
      wave <= 1'b0;
      cyc(5);
      chk(drive_out, rows[i][3:0]);
    end
    // Mixed steer and override, A inverted
    wr(ADDR_ISM, 8'h00);
    target <= 4'h8;
    wr(ADDR_CON1, 8'h01);
    wr(ADDR_STR, 8'h65);
    wave <= 1'b1;
    cyc(5);
    chk(drive_out, 32'h6);
    wave <= 1'b0;
    cyc(5);
    chk(drive_out, 32'h3);
    // Synchronous steering: new enables wait for an input rising edge
    wr(ADDR_CON1, 8'h00);
    wr(ADDR_STR, 8'h00);
    wr(ADDR_CON0, 8'h81);
    wave <= 1'b1;
    cyc(5);
    wr(ADDR_STR, 8'h0f);
    cyc(5);
    chk(drive_out, 32'h0);
    wave <= 1'b0;
    cyc(5);
    wave <= 1'b1;
    cyc(5);
    chk(drive_out, 32'hf);
    // Each shutdown source alone, then all others while only it is enabled
    wr(ADDR_CON0, 8'h80);
    for (i = 0; i < 7; i++) begin
      wr(ADDR_AS1, 8'h01 << i);
      shdn_set <= 7'h01 << i;
      cyc(4);
      chk(shutdown_req, 32'h1);
      shdn_set <= 7'h7f & ~(7'h01 << i);
      cyc(4);
      chk(shutdown_req, 32'h0);
    end
    // Outputs stay shut after the flag clears until an input rising edge
    shdn_set <= 7'h00;
    wr(ADDR_AS1, 8'h01);
    wr(ADDR_AS0, 8'h14);
    wave <= 1'b0;
    cyc(5);
    wave <= 1'b1;
    cyc(5);
    chk(drive_out, 32'hf);
    shdn_set <= 7'h01;
    cyc(4);
    shdn_set <= 7'h00;
    cyc(4);
    chk(drive_out, 32'h0);
    rchk(ADDR_AS0, 32'h94);
    wr(ADDR_AS0, 8'h14);
    cyc(5);
    chk(drive_out, 32'h0);
    wave <= 1'b0;
    cyc(5);
    wave <= 1'b1;
    cyc(5);
    chk(drive_out, 32'hf);
    // Non-steering mode ignores steering, outputs show polarity level
    wr(ADDR_CON1, 8'h05);
    wr(ADDR_CON0, 8'h82);
    cyc(5);
    chk(drive_out, 32'h5);
    // Reset in mid-run
    presetn <= 1'b0;
    cyc(2);
    chk({fast_clk_sel, shutdown_req, drive_out}, 32'h0);
    presetn <= 1'b1;
    rchk(ADDR_STR, 32'h00);
    rchk(ADDR_AS1, 32'h80);
    results;
  end
endmodule
`default_nettype wire
